// ---- spv_cfg.svh ----
// register map, field positions, reset values and timing figures of the synthesizer control
`ifndef SPV_CFG_SVH
`define SPV_CFG_SVH

// register offsets
`define SPV_A_DEV_CTL   6'h00
`define SPV_A_TX_OPT    6'h02
`define SPV_A_MISC2     6'h0E
`define SPV_A_OSC_CTL   6'h11
`define SPV_A_PUMP_CTL  6'h12
`define SPV_A_MOD3      6'h15
`define SPV_A_MAIN1     6'h17
`define SPV_A_MAIN2     6'h18
`define SPV_A_MAIN3     6'h19
`define SPV_A_AUX1      6'h1A
`define SPV_A_AUX2      6'h1B
`define SPV_A_AUX3      6'h1C
`define SPV_A_PAGE_SEL  6'h29
`define SPV_A_INT_STAT  6'h2A
`define SPV_A_PAGED     6'h2C
`define SPV_A_CMD_STAT  6'h2E

// direct command codes
`define SPV_C_HOP_MAIN  8'h84
`define SPV_C_HOP_AUX   8'h85
`define SPV_C_SEG_AUTO  8'hA4
`define SPV_C_SEG_MAN   8'hA5

// device_state_control bits
`define SPV_B_CARRIER   1
`define SPV_B_RX_ONLY   2
`define SPV_B_AGC       3
`define SPV_B_STBY      7
// field positions elsewhere
`define SPV_B_MEAS      7
`define SPV_F_RAMP      7:6
`define SPV_F_XOSC      4:3
`define SPV_F_TARI      2:0
`define SPV_F_REF       6:4
`define SPV_F_PAGE      1:0
`define SPV_F_PUMP      2:0
`define SPV_F_FILT_R    7:6
`define SPV_F_FILT_C    5:3
// A and B inside the 24-bit concatenation of one divider set
`define SPV_F_DIV_A     9:0
`define SPV_F_DIV_B     19:10
`define SPV_B_READY     7
`define SPV_B_SEG_DONE  0
`define SPV_PAGE_SEG    2'h1

// reset values
`define SPV_R_ZERO      8'h00
`define SPV_R_OSC       8'h08

// crystal mode field codes
`define SPV_XO_FAST     2'h1
`define SPV_XO_SAVE     2'h2

// ramp field codes
`define SPV_RMP_100     2'h0
`define SPV_RMP_200     2'h1
`define SPV_RMP_400     2'h2

// timing figures
`define SPV_CLK_MHZ     40
`define SPV_RAMP1_US    100
`define SPV_RAMP2_US    200
`define SPV_RAMP4_US    400
`define SPV_TARI_US     25
`define SPV_XO_FAST_US  50
`define SPV_SETTLE_US   10

`endif

// ---- spv_pkg.sv ----
// shared types of the synthesizer control
`default_nettype none
package spv_pkg;

  // carrier ramp sequencer, one-hot
  typedef enum logic [3:0] {
    CAR_OFF  = 4'b0001,
    CAR_UP   = 4'b0010,
    CAR_ON   = 4'b0100,
    CAR_DOWN = 4'b1000
  } spv_car_t;

  // segment search sequencer, one-hot
  typedef enum logic [2:0] {
    SRCH_IDLE  = 3'b001,
    SRCH_WAIT  = 3'b010,
    SRCH_JUDGE = 3'b100
  } spv_srch_t;

  // divider word applied to the prescaler
  typedef struct packed {
    logic [9:0]  b;
    logic [9:0]  a;
    logic [16:0] n;
  } spv_div_t;

  // loop option fields
  typedef struct packed {
    logic [2:0] ref_sel;
    logic [2:0] pump;
    logic [1:0] filt_r;
    logic [2:0] filt_c;
  } spv_loop_t;

endpackage : spv_pkg
`default_nettype wire

// ---- spv_synth_ctl.sv ----
// synthesizer, oscillator segment and carrier ramp control behind the register port
//
// Function
// - auto command runs segment search
// - manual command returns to written segment
// - search done sets flag and interrupt
// - manual segment from oscillator control field
// - segment selector spans exactly sixteen ranges
// - search result readable on status page one
// - measurement result shown while measure bit set
// - three registers hold A and B
// - ratio equals B*32 plus A*33
// - hop commands pick main or aux
// - reference field selects comparison rate
// - crystal fast start then saving, overridable
// - pump current field drives pump
// - filter resistor and capacitor fields
// - carrier enable turns on tx and rx
// - ramp time from ramp and tari fields
// - ramp done sets ready and interrupt
// - carrier off ramps down then interrupts
// - receiver, gain control, standby bits
// - commands take effect at once, search runs on, accesses follow
`include "spv_cfg.svh"
`default_nettype none
module spv_synth_ctl #(
  parameter int RAMP1_CYC = `SPV_RAMP1_US * `SPV_CLK_MHZ,
  parameter int RAMP2_CYC = `SPV_RAMP2_US * `SPV_CLK_MHZ,
  parameter int RAMP4_CYC = `SPV_RAMP4_US * `SPV_CLK_MHZ,
  parameter int TARI_CYC  = `SPV_TARI_US * `SPV_CLK_MHZ,
  parameter int XO_CYC    = `SPV_XO_FAST_US * `SPV_CLK_MHZ,
  parameter int SETTLE_CYC = `SPV_SETTLE_US * `SPV_CLK_MHZ,
  parameter int SEG_W     = 4
) (
  input  wire logic            clock_i,
  input  wire logic            rst_n_i,
  // register port from the serial decoder
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  input  wire logic [5:0]      reg_addr_i,
  input  wire logic [7:0]      reg_wdata_i,
  output logic      [7:0]      reg_rdata_o,
  // direct command strobe
  input  wire logic            cmd_valid_i,
  input  wire logic [7:0]      cmd_code_i,
  // analog feedback
  input  wire logic            tune_high_i,
  input  wire logic [2:0]      tune_meas_i,
  // analog controls and interrupts
  output logic [SEG_W-1:0]     segment_o,
  output spv_pkg::spv_div_t    divider_o,
  output spv_pkg::spv_loop_t   loop_o,
  output logic                 tune_meas_en_o,
  output logic                 xosc_fast_o,
  output logic                 tx_en_o,
  output logic                 rx_en_o,
  output logic                 agc_en_o,
  output logic                 standby_o,
  output logic                 ramp_up_o,
  output logic                 ramp_down_o,
  output logic                 irq_cmd_o,
  output logic                 irq_ana_o
);

  localparam int CW = 16;                 // wide enough for the longest ramp count

  // host-written registers
  logic [7:0] dev_ctl_reg;                // device_state_control
  logic [7:0] tx_opt_reg;                 // transmit_options
  logic [7:0] misc2_reg;                  // misc_config_two
  logic [7:0] osc_ctl_reg;                // oscillator_control
  logic [7:0] pump_reg;                   // charge_pump_filter_control
  logic [7:0] mod3_reg;                   // modulator_control_three
  logic [7:0] main_reg [3];               // main_divider_one..three
  logic [7:0] aux_reg  [3];               // aux_divider_one..three
  logic [7:0] page_reg;                   // status_page_select

  // block state
  logic                 use_aux_reg;      // divider source flag
  logic                 auto_seg_reg;     // segment from search, not host
  logic [SEG_W-1:0]     found_seg_reg;    // last search result
  logic [SEG_W-1:0]     trial_reg;        // segment under test
  logic [SEG_W-1:0]     bit_reg;          // one-hot bit under test
  logic                 seg_done_reg;     // sticky search-done status
  logic [CW-1:0]        srch_cnt_reg;     // settle timer
  spv_pkg::spv_srch_t   srch_reg;
  spv_pkg::spv_car_t    car_reg;
  logic [CW-1:0]        ramp_cnt_reg;     // ramp timer
  logic [CW-1:0]        ramp_len;         // chosen ramp length
  logic [CW-1:0]        xo_cnt_reg;       // crystal fast-start timer
  logic                 xo_start_reg;     // still in fast start

  logic wr_dev, wr_main, wr_aux;
  logic cmd_hop_main, cmd_hop_aux, cmd_auto, cmd_man;
  logic [1:0] main_idx, aux_idx;

  // command decode; every command takes effect in its own cycle, so the
  // next register access may follow on the next clock
  assign cmd_hop_main = cmd_valid_i && (cmd_code_i == `SPV_C_HOP_MAIN);
  assign cmd_hop_aux  = cmd_valid_i && (cmd_code_i == `SPV_C_HOP_AUX);
  assign cmd_auto     = cmd_valid_i && (cmd_code_i == `SPV_C_SEG_AUTO);
  assign cmd_man      = cmd_valid_i && (cmd_code_i == `SPV_C_SEG_MAN);

  assign wr_dev  = reg_wr_i && (reg_addr_i == `SPV_A_DEV_CTL);
  // divider sets sit on three consecutive offsets
  assign wr_main = reg_wr_i && (reg_addr_i >= `SPV_A_MAIN1) && (reg_addr_i <= `SPV_A_MAIN3);
  assign wr_aux  = reg_wr_i && (reg_addr_i >= `SPV_A_AUX1) && (reg_addr_i <= `SPV_A_AUX3);
  assign main_idx = 2'(reg_addr_i - `SPV_A_MAIN1);
  assign aux_idx  = 2'(reg_addr_i - `SPV_A_AUX1);

  // plain control registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dev_ctl_reg <= `SPV_R_ZERO;
      tx_opt_reg  <= `SPV_R_ZERO;
      misc2_reg   <= `SPV_R_ZERO;
      osc_ctl_reg <= `SPV_R_OSC;
      pump_reg    <= `SPV_R_ZERO;
      mod3_reg    <= `SPV_R_ZERO;
      page_reg    <= `SPV_R_ZERO;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `SPV_A_DEV_CTL:  dev_ctl_reg <= reg_wdata_i;
        `SPV_A_TX_OPT:   tx_opt_reg  <= reg_wdata_i;
        `SPV_A_MISC2:    misc2_reg   <= reg_wdata_i;
        `SPV_A_OSC_CTL:  osc_ctl_reg <= reg_wdata_i;
        `SPV_A_PUMP_CTL: pump_reg    <= reg_wdata_i;
        `SPV_A_MOD3:     mod3_reg    <= reg_wdata_i;
        `SPV_A_PAGE_SEL: page_reg    <= reg_wdata_i;
        default: ;                                     // others live elsewhere or read-only
      endcase
    end
  end

  // the two divider sets, one generate entry per byte
  for (genvar i = 0; i < 3; i++) begin : g_div
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        main_reg[i] <= `SPV_R_ZERO;
        aux_reg[i]  <= `SPV_R_ZERO;
      end else begin
        if (wr_main && main_idx == 2'(i)) begin
          main_reg[i] <= reg_wdata_i;
        end
        // aux may be reloaded while main drives the loop
        if (wr_aux && aux_idx == 2'(i)) begin
          aux_reg[i] <= reg_wdata_i;
        end
      end
    end
  end

  // hop commands only flip the source flag
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      use_aux_reg <= 1'b0;
    end else if (cmd_hop_aux) begin
      use_aux_reg <= 1'b1;
    end else if (cmd_hop_main) begin
      use_aux_reg <= 1'b0;
    end
  end

  // divider word: A and B always taken from the same set in one edge
  // so the prescaler never sees half of each set
  logic [23:0] set_w;
  logic [9:0]  a_w, b_w;
  assign set_w = use_aux_reg ? {aux_reg[2], aux_reg[1], aux_reg[0]}
                             : {main_reg[2], main_reg[1], main_reg[0]};
  assign a_w = set_w[`SPV_F_DIV_A];
  assign b_w = set_w[`SPV_F_DIV_B];

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      divider_o <= '0;
    end else begin
      divider_o.a <= a_w;
      divider_o.b <= b_w;
      // B*32 + A*33 = (A+B)*32 + A
      divider_o.n <= 17'({b_w, 5'h00}) + 17'({a_w, 5'h00}) + 17'(a_w);
    end
  end

  // loop option fields; the host is expected to set these and the main
  // set before enabling the carrier, nothing here enforces it
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      loop_o <= '0;
    end else begin
      loop_o.ref_sel <= main_reg[0][`SPV_F_REF];
      loop_o.pump    <= pump_reg[`SPV_F_PUMP];
      loop_o.filt_r  <= pump_reg[`SPV_F_FILT_R];
      loop_o.filt_c  <= pump_reg[`SPV_F_FILT_C];
    end
  end

  // segment search: successive approximation, one bit per settle period,
  // four bits cover the sixteen ranges
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      srch_reg      <= spv_pkg::SRCH_IDLE;
      trial_reg     <= '0;
      bit_reg       <= '0;
      srch_cnt_reg  <= '0;
      found_seg_reg <= '0;
    end else begin
      unique case (srch_reg)
        spv_pkg::SRCH_IDLE: begin
          if (cmd_auto) begin
            trial_reg    <= {1'b1, {(SEG_W-1){1'b0}}};
            bit_reg      <= {1'b1, {(SEG_W-1){1'b0}}};
            srch_cnt_reg <= CW'(SETTLE_CYC - 1);
            srch_reg     <= spv_pkg::SRCH_WAIT;
          end
        end
        spv_pkg::SRCH_WAIT: begin
          // let the loop settle on the trial segment
          if (srch_cnt_reg == '0) begin
            srch_reg <= spv_pkg::SRCH_JUDGE;
          end else begin
            srch_cnt_reg <= srch_cnt_reg - CW'(1);
          end
        end
        spv_pkg::SRCH_JUDGE: begin
          // high tuning voltage means the segment is too low: keep the bit
          if (bit_reg == {{(SEG_W-1){1'b0}}, 1'b1}) begin
            found_seg_reg <= tune_high_i ? trial_reg : (trial_reg & ~bit_reg);
            srch_reg      <= spv_pkg::SRCH_IDLE;
          end else begin
            trial_reg    <= (tune_high_i ? trial_reg : (trial_reg & ~bit_reg))
                            | (bit_reg >> 1);
            bit_reg      <= bit_reg >> 1;
            srch_cnt_reg <= CW'(SETTLE_CYC - 1);
            srch_reg     <= spv_pkg::SRCH_WAIT;
          end
        end
      endcase
    end
  end

  logic srch_end;
  assign srch_end = (srch_reg == spv_pkg::SRCH_JUDGE) && (bit_reg == {{(SEG_W-1){1'b0}}, 1'b1});

  // segment source: manual command wins back the host field at once, or when a running search ends
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      auto_seg_reg <= 1'b0;
    end else if (cmd_man) begin
      auto_seg_reg <= 1'b0;
    end else if (cmd_auto) begin
      auto_seg_reg <= 1'b1;
    end
  end

  // applied segment; during a search the trial drives, the host field is
  // ignored, and the result holds after the search
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      segment_o <= '0;
    end else if (srch_reg != spv_pkg::SRCH_IDLE) begin
      segment_o <= trial_reg;
    end else if (auto_seg_reg) begin
      segment_o <= found_seg_reg;
    end else begin
      segment_o <= osc_ctl_reg[SEG_W-1:0];
    end
  end

  // search-done status: set wins over the clear from a new search start
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      seg_done_reg <= 1'b0;
      irq_cmd_o    <= 1'b0;
    end else begin
      irq_cmd_o <= srch_end;
      if (srch_end) begin
        seg_done_reg <= 1'b1;
      end else if (cmd_auto) begin
        seg_done_reg <= 1'b0;
      end
    end
  end

  // measurement enable follows the host bit
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tune_meas_en_o <= 1'b0;
    end else begin
      tune_meas_en_o <= osc_ctl_reg[`SPV_B_MEAS];
    end
  end

  // crystal: fast start after reset, then saving; field overrides
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      xo_cnt_reg   <= CW'(XO_CYC - 1);
      xo_start_reg <= 1'b1;
      xosc_fast_o  <= 1'b1;
    end else begin
      if (xo_start_reg) begin
        if (xo_cnt_reg == '0) begin
          xo_start_reg <= 1'b0;
        end else begin
          xo_cnt_reg <= xo_cnt_reg - CW'(1);
        end
      end
      unique case (misc2_reg[`SPV_F_XOSC])
        `SPV_XO_FAST: xosc_fast_o <= 1'b1;
        `SPV_XO_SAVE: xosc_fast_o <= 1'b0;
        default:      xosc_fast_o <= xo_start_reg;
      endcase
    end
  end

  // ramp length from the ramp field, or from the tari setting
  always_comb begin
    unique case (mod3_reg[`SPV_F_RAMP])
      `SPV_RMP_100: ramp_len = CW'(RAMP1_CYC);
      `SPV_RMP_200: ramp_len = CW'(RAMP2_CYC);
      `SPV_RMP_400: ramp_len = CW'(RAMP4_CYC);
      default:      ramp_len = CW'(TARI_CYC) * CW'({1'b0, tx_opt_reg[`SPV_F_TARI]} + 4'h1);
    endcase
  end

  logic car_req;
  assign car_req = dev_ctl_reg[`SPV_B_CARRIER];

  // carrier sequencer; a request reversal mid-ramp turns around at once
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      car_reg      <= spv_pkg::CAR_OFF;
      ramp_cnt_reg <= '0;
      irq_ana_o    <= 1'b0;
    end else begin
      irq_ana_o <= 1'b0;
      unique case (car_reg)
        spv_pkg::CAR_OFF: begin
          if (car_req) begin
            ramp_cnt_reg <= ramp_len - CW'(1);
            car_reg      <= spv_pkg::CAR_UP;
          end
        end
        spv_pkg::CAR_UP: begin
          if (!car_req) begin
            ramp_cnt_reg <= ramp_len - CW'(1);
            car_reg      <= spv_pkg::CAR_DOWN;
          end else if (ramp_cnt_reg == '0) begin
            car_reg   <= spv_pkg::CAR_ON;
            irq_ana_o <= 1'b1;
          end else begin
            ramp_cnt_reg <= ramp_cnt_reg - CW'(1);
          end
        end
        spv_pkg::CAR_ON: begin
          if (!car_req) begin
            ramp_cnt_reg <= ramp_len - CW'(1);
            car_reg      <= spv_pkg::CAR_DOWN;
          end
        end
        spv_pkg::CAR_DOWN: begin
          if (car_req) begin
            ramp_cnt_reg <= ramp_len - CW'(1);
            car_reg      <= spv_pkg::CAR_UP;
          end else if (ramp_cnt_reg == '0) begin
            car_reg   <= spv_pkg::CAR_OFF;
            irq_ana_o <= 1'b1;
          end else begin
            ramp_cnt_reg <= ramp_cnt_reg - CW'(1);
          end
        end
      endcase
    end
  end

  // enables to the analog blocks
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tx_en_o     <= 1'b0;
      rx_en_o     <= 1'b0;
      agc_en_o    <= 1'b0;
      standby_o   <= 1'b0;
      ramp_up_o   <= 1'b0;
      ramp_down_o <= 1'b0;
    end else begin
      // transmitter stays on through the ramp-down tail
      tx_en_o     <= car_req || (car_reg != spv_pkg::CAR_OFF);
      rx_en_o     <= car_req || dev_ctl_reg[`SPV_B_RX_ONLY];
      agc_en_o    <= dev_ctl_reg[`SPV_B_AGC];
      standby_o   <= dev_ctl_reg[`SPV_B_STBY];
      ramp_up_o   <= (car_reg == spv_pkg::CAR_UP);
      ramp_down_o <= (car_reg == spv_pkg::CAR_DOWN);
    end
  end

  // read path, one cycle after the read strobe; unmapped offsets read zero
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `SPV_R_ZERO;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `SPV_A_DEV_CTL:  reg_rdata_o <= dev_ctl_reg;
        `SPV_A_TX_OPT:   reg_rdata_o <= tx_opt_reg;
        `SPV_A_MISC2:    reg_rdata_o <= misc2_reg;
        `SPV_A_OSC_CTL:  reg_rdata_o <= osc_ctl_reg;
        `SPV_A_PUMP_CTL: reg_rdata_o <= pump_reg;
        `SPV_A_MOD3:     reg_rdata_o <= mod3_reg;
        `SPV_A_MAIN1:    reg_rdata_o <= main_reg[0];
        `SPV_A_MAIN2:    reg_rdata_o <= main_reg[1];
        `SPV_A_MAIN3:    reg_rdata_o <= main_reg[2];
        `SPV_A_AUX1:     reg_rdata_o <= aux_reg[0];
        `SPV_A_AUX2:     reg_rdata_o <= aux_reg[1];
        `SPV_A_AUX3:     reg_rdata_o <= aux_reg[2];
        `SPV_A_PAGE_SEL: reg_rdata_o <= page_reg;
        `SPV_A_INT_STAT: begin
          reg_rdata_o <= `SPV_R_ZERO;
          reg_rdata_o[`SPV_B_READY] <= (car_reg == spv_pkg::CAR_ON);
        end
        `SPV_A_PAGED: begin
          if (page_reg[`SPV_F_PAGE] == `SPV_PAGE_SEG) begin
            reg_rdata_o <= {found_seg_reg, 1'b0,
                            osc_ctl_reg[`SPV_B_MEAS] ? tune_meas_i : 3'h0};
          end else begin
            reg_rdata_o <= `SPV_R_ZERO;
          end
        end
        `SPV_A_CMD_STAT: begin
          reg_rdata_o <= `SPV_R_ZERO;
          reg_rdata_o[`SPV_B_SEG_DONE] <= seg_done_reg;
        end
        default: reg_rdata_o <= `SPV_R_ZERO;
      endcase
    end
  end

endmodule : spv_synth_ctl
`default_nettype wire

// ---- spv_synth_props.sv ----
// assertion checker watching the synthesizer control ports
`default_nettype none
module spv_synth_props (
  input wire logic               clock_i,
  input wire logic               rst_n_i,
  input wire logic               reg_wr_i,
  input wire logic [5:0]         reg_addr_i,
  input wire logic [7:0]         reg_wdata_i,
  input wire spv_pkg::spv_div_t  divider_o,
  input wire spv_pkg::spv_loop_t loop_o,
  input wire logic               tune_meas_en_o,
  input wire logic               xosc_fast_o,
  input wire logic               tx_en_o,
  input wire logic               rx_en_o,
  input wire logic               ramp_up_o,
  input wire logic               ramp_down_o,
  input wire logic               irq_cmd_o,
  input wire logic               irq_ana_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // the applied word must always be self consistent, even across a hop
  div_ratio_a: assert property (divider_o.n == 17'(divider_o.b * 32 + divider_o.a * 33))
    else $error("divider ratio wrong");
  meas_mirror_a: assert property (reg_wr_i && reg_addr_i == 6'h11 |-> ##2
    tune_meas_en_o == $past(reg_wdata_i[7], 2)) else $error("measure enable wrong");
  loop_fields_a: assert property (reg_wr_i && reg_addr_i == 6'h12 |-> ##2
    {loop_o.filt_r, loop_o.filt_c, loop_o.pump} == $past(reg_wdata_i, 2))
    else $error("pump or filter field wrong");
  ref_field_a: assert property (reg_wr_i && reg_addr_i == 6'h17 |-> ##2
    loop_o.ref_sel == $past(reg_wdata_i[6:4], 2)) else $error("reference select wrong");
  carrier_on_a: assert property ($rose(ramp_up_o) |-> tx_en_o && rx_en_o)
    else $error("ramp without tx and rx");
  ana_cause_a: assert property (irq_ana_o |-> $past(ramp_up_o) || $past(ramp_down_o) ||
    $past(ramp_up_o, 2) || $past(ramp_down_o, 2)) else $error("analog irq without ramp");
  ana_pulse_a: assert property (irq_ana_o |=> !irq_ana_o)
    else $error("analog irq longer than one cycle");
  cmd_pulse_a: assert property (irq_cmd_o |=> !irq_cmd_o)
    else $error("command irq longer than one cycle");
  // the fast start outlasts eight cycles for any sane start length
  xosc_start_a: assert property ($rose(rst_n_i) |-> xosc_fast_o [*8])
    else $error("crystal not in fast start");
endmodule : spv_synth_props
bind spv_synth_ctl spv_synth_props u_spv_synth_props (.clock_i, .rst_n_i, .reg_wr_i,
  .reg_addr_i, .reg_wdata_i, .divider_o, .loop_o, .tune_meas_en_o, .xosc_fast_o, .tx_en_o,
  .rx_en_o, .ramp_up_o, .ramp_down_o, .irq_cmd_o, .irq_ana_o);
`default_nettype wire

// ---- spv_host_model.sv ----
// host side model issuing register accesses and direct commands
`default_nettype none
module spv_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] reg_rdata_i,
  output var  logic       reg_wr_o,
  output var  logic       reg_rd_o,
  output var  logic [5:0] reg_addr_o,
  output var  logic [7:0] reg_wdata_o,
  output var  logic       cmd_valid_o,
  output var  logic [7:0] cmd_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    cmd_valid_o = 1'b0;
    reg_addr_o = 6'h00;
    reg_wdata_o = 8'h00;
    cmd_code_o = 8'h00;
  end
  // released lines show the inverse so stale data never looks valid
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask : wr
  // data stands from the edge after the strobe until the next read
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    @(posedge clock_i);
    d = reg_rdata_i;
  endtask : rd
  task automatic cmd(input logic [7:0] c);
    @(posedge clock_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= c;
    @(posedge clock_i);
    cmd_valid_o <= 1'b0;
    cmd_code_o <= ~c;
  endtask : cmd
endmodule : spv_host_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the synthesizer control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RLEN [4] = '{10, 20, 40, 10}; // ramp length per code, last is tari code 1
  logic clock_i = 1'b0, rst_n_i = 1'b0, tune_high_i, reg_wr_i, reg_rd_i, cmd_valid_i;
  logic [5:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, cmd_code_i;
  logic [2:0] tune_meas_i;
  logic [3:0] segment_o, target = 4'hB;
  spv_pkg::spv_div_t divider_o;
  spv_pkg::spv_loop_t loop_o;
  logic tune_meas_en_o, xosc_fast_o, tx_en_o, rx_en_o, agc_en_o, standby_o;
  logic ramp_up_o, ramp_down_o, irq_cmd_o, irq_ana_o;
  int mismatches = 0, n_compared = 0;
  // search settle runs at its full default length so the real timer is exercised
  spv_synth_ctl #(.RAMP1_CYC(10), .RAMP2_CYC(20), .RAMP4_CYC(40), .TARI_CYC(5), .XO_CYC(20)
    ) u_spv_synth_ctl (.clock_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .cmd_valid_i, .cmd_code_i, .tune_high_i, .tune_meas_i,
    .segment_o, .divider_o, .loop_o, .tune_meas_en_o, .xosc_fast_o, .tx_en_o, .rx_en_o,
    .agc_en_o, .standby_o, .ramp_up_o, .ramp_down_o, .irq_cmd_o, .irq_ana_o);
  spv_host_model u_spv_host_model (.clock_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i));
  always #12.5 clock_i = ~clock_i;
  // comparator: voltage reads high while the segment is at or below the target
  always @(posedge clock_i) tune_high_i <= (segment_o <= target);
  task automatic check(input string what, input logic [36:0] seen, input logic [36:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // bounded wait for an interrupt pulse, a hang counts as a mismatch;
  // the bound covers four full-length settle periods of the search
  task automatic wait_irq(input logic ana, output int cnt);
    for (cnt = 1; cnt < 2000; cnt++) begin
      @(posedge clock_i);
      if ((ana ? irq_ana_o : irq_cmd_o) === 1'b1) return;
    end
    mismatches++;
    final_report();
  endtask : wait_irq
  task automatic start_state;
    logic [7:0] d;
    check("xo start", xosc_fast_o, 1'b1);
    u_spv_host_model.rd(6'h11, d);
    check("osc reset", {d, segment_o}, 12'h088);
  endtask : start_state
  task automatic loop_opts;
    u_spv_host_model.wr(6'h12, 8'hEB);
    u_spv_host_model.wr(6'h17, 8'h35);
    repeat (2) @(posedge clock_i);
    check("loop", loop_o, {3'h3, 3'h3, 2'h3, 3'h5});
  endtask : loop_opts
  // load one divider set, hop to it and compare the applied word
  task automatic hop_case(input logic [5:0] base, input logic [7:0] code, input logic [9:0] a,
                          input logic [9:0] b);
    u_spv_host_model.wr(base, a[7:0]);
    u_spv_host_model.wr(base + 6'h1, {b[5:0], a[9:8]});
    u_spv_host_model.wr(base + 6'h2, {4'h0, b[9:6]});
    u_spv_host_model.cmd(code);
    repeat (3) @(posedge clock_i);
    check("divider", divider_o, {b, a, 17'(b * 32 + a * 33)});
  endtask : hop_case
  task automatic hops;
    hop_case(6'h17, 8'h84, 10'h2A5, 10'h1C3);
    hop_case(6'h1A, 8'h85, 10'h011, 10'h3FF);
    hop_case(6'h17, 8'h84, 10'h3FF, 10'h000);
  endtask : hops
  task automatic seg_search;
    logic [7:0] d;
    int cnt;
    u_spv_host_model.cmd(8'hA4);
    u_spv_host_model.wr(6'h11, 8'h03);
    wait_irq(1'b0, cnt);
    repeat (2) @(posedge clock_i);
    check("auto segment", segment_o, 4'hB);
    u_spv_host_model.rd(6'h2E, d);
    check("search done", d[0], 1'b1);
    u_spv_host_model.wr(6'h29, 8'h01);
    u_spv_host_model.wr(6'h11, 8'h83);
    tune_meas_i <= 3'h5;
    u_spv_host_model.rd(6'h2C, d);
    check("paged status", {d, tune_meas_en_o}, 9'h16B);
    u_spv_host_model.cmd(8'hA5);
    repeat (3) @(posedge clock_i);
    check("manual segment", segment_o, 4'h3);
  endtask : seg_search
  task automatic carrier;
    logic [7:0] d;
    int cnt;
    u_spv_host_model.wr(6'h02, 8'h01);
    for (int k = 0; k < 4; k++) begin
      u_spv_host_model.wr(6'h15, 8'(k << 6));
      u_spv_host_model.wr(6'h00, 8'h02);
      wait_irq(1'b1, cnt);
      check("ramp up", cnt >= RLEN[k] && cnt <= RLEN[k] + 6, 1'b1);
      u_spv_host_model.rd(6'h2A, d);
      check("ready", {d[7], tx_en_o, rx_en_o, ramp_up_o, ramp_down_o}, 5'h1C);
      u_spv_host_model.wr(6'h00, 8'h00);
      wait_irq(1'b1, cnt);
      check("ramp down", cnt >= RLEN[k] && cnt <= RLEN[k] + 6, 1'b1);
    end
  endtask : carrier
  task automatic modes;
    u_spv_host_model.wr(6'h00, 8'h8C);
    repeat (2) @(posedge clock_i);
    check("modes", {tx_en_o, rx_en_o, agc_en_o, standby_o}, 4'h7);
    check("xo auto", xosc_fast_o, 1'b0);
    u_spv_host_model.wr(6'h0E, 8'h08);
    repeat (2) @(posedge clock_i);
    check("xo forced", xosc_fast_o, 1'b1);
    u_spv_host_model.wr(6'h0E, 8'h10);
    repeat (2) @(posedge clock_i);
    check("xo saving", xosc_fast_o, 1'b0);
  endtask : modes
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    start_state();
    loop_opts();
    hops();
    seg_search();
    carrier();
    modes();
    final_report();
  end
endmodule : testbench
`default_nettype wire
